//--- hw/motor_bus_defines.svh
`ifndef MOTOR_BUS_DEFINES_SVH
`define MOTOR_BUS_DEFINES_SVH

// clock and internal oscillator rates
`define CLK_MHZ 200
`define OSC_KHZ 250
`define OSC_DIV ((`CLK_MHZ * 1000) / `OSC_KHZ)

// select-low clear time and overcurrent switch-off time, in microseconds
`define CLEAR_HOLD_TIME_US 100
`define OVC_OFF_TIME_US 100
`define CLEAR_TICKS ((`CLEAR_HOLD_TIME_US * `OSC_KHZ) / 1000)
`define OVC_TICKS ((`OVC_OFF_TIME_US * `OSC_KHZ) / 1000)

// host-side bus limits, microseconds
`define SEL_LOW_MIN_US 20
`define SEL_LOW_MAX_US 90
`define DIAG_VALID_MAX_US 10
`define DIAG_VALID_MAX_CYC ((`DIAG_VALID_MAX_US * `CLK_MHZ))

// apb register byte offsets
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CMD_OFFSET 8'h08

// field positions
`define CTRL_FORCE_STANDBY 0
`define STATUS_STATE_LSB 0
`define STATUS_BR_OVC 2
`define STATUS_HS_OVC 3
`define STATUS_LEVEL_LSB 4

// reset values
`define CTRL_RESET 1'b0
`define DATA_CLEAR_CODE 4'hf

`endif

//--- hw/motor_bus_pkg.sv
package motor_bus_pkg;

    // drive condition of one power output
    typedef enum logic [2:0] {
        DRV_OFF,
        DRV_SRC,
        DRV_SNK,
        DRV_SRC_140,
        DRV_SNK_140,
        DRV_SRC_10,
        DRV_SNK_10
    } drive_t;

    typedef struct packed {
        drive_t high_side;
        drive_t bridge_4;
        drive_t bridge_3;
        drive_t bridge_2;
        drive_t bridge_1;
    } drive_set_t;

    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_LOCKED,
        ST_STANDBY,
        ST_ACTIVE
    } link_state_t;

endpackage : motor_bus_pkg

//--- hw/ovc_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ovc_timer #(
    parameter int TICKS = 25
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic armed,
    input wire logic vds_high,
    input wire logic rearm,
    output logic trip,
    output logic tripped
);

    localparam int CW = $clog2(TICKS + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tripped_r;
    logic tripped_nxt;
    logic limiting;

    // counts oscillator ticks only while the output is on and in current limit
    assign limiting = armed & vds_high & ~tripped_r;
    assign trip = limiting & tick & (cnt_r == CW'(TICKS - 1));
    assign cnt_nxt = !limiting ? '0 : (tick ? cnt_r + CW'(1) : cnt_r);
    // a trip in the rearm cycle still wins
    assign tripped_nxt = trip | (tripped_r & ~rearm);
    assign tripped = tripped_r;

    // timer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tripped_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tripped_r <= tripped_nxt;
        end
    end

endmodule : ovc_timer

`default_nettype wire

//--- hw/motor_driver_bus_control.sv
// Summary of operation
// - read mode low returns four bridge levels
// - read mode high returns fault code, overtemp, high-side
// - level bit high above 60%, low below 40%
// - write mode high selects load test currents
// - write mode low data 1111 clears all
// - select low 100us clears and enters standby
// - after power-up, long select low gives standby
// - select high at power-up gives standby
// - select low at power-up ignores bus
// - high-side full drive only enabled with bridges tristate
// - select low write executes, rising edge stores
// - select high ignores every bus input after the rising edge
// - select low read drives diagnostics, outputs hold
// - read/write may change while selected
// - limited output with high drop starts timer
// - timer expiry switches output off, sets flag
// - next write command re-enables tripped output
// - select window from oscillator, diag delay from pclk
// - overcurrent flags latched until next write or standby
// - selected write is transparent to outputs
// - write mode low decodes motor, brake, high-side
// - rising select with all inputs low: standby
`include "motor_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module motor_driver_bus_control #(
    parameter int OSC_DIV = `OSC_DIV,
    parameter int CLEAR_TICKS = `CLEAR_TICKS,
    parameter int OVC_TICKS = `OVC_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_select_low,
    input wire logic read_not_write,
    input wire logic mode,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic data_oe,
    input wire logic [4:0] level_above_60,
    input wire logic [4:0] level_below_40,
    input wire logic [4:0] vds_above_40,
    input wire logic overtemp_in,
    input wire logic overvoltage_in,
    output motor_bus_pkg::drive_t bridge_output_1,
    output motor_bus_pkg::drive_t bridge_output_2,
    output motor_bus_pkg::drive_t bridge_output_3,
    output motor_bus_pkg::drive_t bridge_output_4,
    output motor_bus_pkg::drive_t high_side_output,
    output logic standby
);

    localparam int DW = $clog2(OSC_DIV);
    localparam int LW = $clog2(CLEAR_TICKS + 1);

    // command decode used by the live path only
    function automatic motor_bus_pkg::drive_set_t decode_cmd(input logic md, input logic [3:0] d);
        motor_bus_pkg::drive_set_t s;
        s = '{default: motor_bus_pkg::DRV_OFF};
        if (!md) begin
            unique case (d)
                4'h4: begin s.bridge_1 = motor_bus_pkg::DRV_SRC; s.bridge_4 = motor_bus_pkg::DRV_SNK; end
                4'h3: begin s.bridge_1 = motor_bus_pkg::DRV_SNK; s.bridge_4 = motor_bus_pkg::DRV_SRC; end
                4'h5: begin s.bridge_2 = motor_bus_pkg::DRV_SRC; s.bridge_4 = motor_bus_pkg::DRV_SNK; end
                4'h2: begin s.bridge_2 = motor_bus_pkg::DRV_SNK; s.bridge_4 = motor_bus_pkg::DRV_SRC; end
                4'h6: begin s.bridge_3 = motor_bus_pkg::DRV_SRC; s.bridge_4 = motor_bus_pkg::DRV_SNK; end
                4'h1: begin s.bridge_3 = motor_bus_pkg::DRV_SNK; s.bridge_4 = motor_bus_pkg::DRV_SRC; end
                4'h7: begin
                    s.bridge_1 = motor_bus_pkg::DRV_SNK;
                    s.bridge_2 = motor_bus_pkg::DRV_SNK;
                    s.bridge_3 = motor_bus_pkg::DRV_SNK;
                    s.bridge_4 = motor_bus_pkg::DRV_SNK;
                end
                4'h8: s.high_side = motor_bus_pkg::DRV_SRC;
                default: s = '{default: motor_bus_pkg::DRV_OFF};
            endcase
        end else begin
            unique case (d[2:0])
                3'h2: s.bridge_4 = motor_bus_pkg::DRV_SRC_140;
                3'h1: s.bridge_4 = motor_bus_pkg::DRV_SNK_140;
                3'h6: begin
                    s.bridge_1 = motor_bus_pkg::DRV_SNK_10;
                    s.bridge_2 = motor_bus_pkg::DRV_SNK_10;
                    s.bridge_3 = motor_bus_pkg::DRV_SNK_10;
                    s.bridge_4 = motor_bus_pkg::DRV_SRC_140;
                    s.high_side = motor_bus_pkg::DRV_SRC_10;
                end
                default: s = '{default: motor_bus_pkg::DRV_OFF};
            endcase
        end
        return s;
    endfunction : decode_cmd

    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic cs_prev_r;
    logic [1:0] start_cnt_r;
    logic [DW-1:0] div_cnt_r;
    logic tick_r;
    logic [LW-1:0] low_cnt_r;
    logic [LW-1:0] low_cnt_nxt;
    motor_bus_pkg::link_state_t state_r;
    motor_bus_pkg::link_state_t state_nxt;
    motor_bus_pkg::drive_set_t cmd_r;
    motor_bus_pkg::drive_set_t cmd_nxt;
    motor_bus_pkg::drive_set_t drv_r;
    motor_bus_pkg::drive_set_t drv_nxt;
    logic wrote_r;
    logic [4:0] lvl_r;
    logic [4:0] lvl_nxt;
    logic br_ovc_r;
    logic hs_ovc_r;
    logic [3:0] data_out_r;
    logic data_oe_r;
    logic standby_r;
    logic ctrl_force_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic cs_s;
    logic rw_s;
    logic mode_s;
    logic [3:0] data_s;
    logic fall;
    logic rise;
    logic start_done;
    logic low_expired;
    logic active;
    logic wr_cycle;
    logic rd_cycle;
    logic zero_inputs;
    logic rearm;
    logic [4:0] armed;
    logic [4:0] trip;
    logic [4:0] tripped;
    logic [3:0] diag;
    logic [1:0] fault_code;
    logic access;
    logic apb_wr;
    logic sel_ctrl;
    logic sel_status;
    logic sel_cmd;
    logic [31:0] rd_mux;

    // synchronised pins: first stage feeds only the second
    assign cs_s = sync2_r[6];
    assign rw_s = sync2_r[5];
    assign mode_s = sync2_r[4];
    assign data_s = sync2_r[3:0];
    assign fall = cs_prev_r & ~cs_s;
    assign rise = ~cs_prev_r & cs_s;
    assign start_done = (start_cnt_r == 2'h3);
    assign active = (state_r == motor_bus_pkg::ST_ACTIVE);
    assign wr_cycle = active & ~cs_s & ~rw_s;
    assign rd_cycle = active & ~cs_s & rw_s;
    assign zero_inputs = ~rw_s & ~mode_s & (data_s == 4'h0);
    assign low_expired = (low_cnt_r >= LW'(CLEAR_TICKS));

    // two-stage sync of the bus pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 7'h40;
            sync2_r <= 7'h40;
            cs_prev_r <= 1'b1;
            start_cnt_r <= 2'h0;
        end else begin
            sync1_r <= {chip_select_low, read_not_write, mode, data_in};
            sync2_r <= sync1_r;
            cs_prev_r <= cs_s;
            start_cnt_r <= start_done ? start_cnt_r : start_cnt_r + 2'h1;
        end
    end

    // oscillator tick divided down from pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_cnt_r <= (div_cnt_r == DW'(OSC_DIV - 1)) ? '0 : div_cnt_r + DW'(1);
            tick_r <= (div_cnt_r == DW'(OSC_DIV - 1));
        end
    end

    // select-low time in oscillator ticks, saturating
    assign low_cnt_nxt = cs_s ? '0 : ((tick_r && !low_expired) ? low_cnt_r + LW'(1) : low_cnt_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_r <= '0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end

    // link state; standby can be left only by a fresh falling select edge
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            motor_bus_pkg::ST_POWERUP: begin
                if (start_done && cs_s) begin
                    state_nxt = motor_bus_pkg::ST_STANDBY;
                end else if (start_done) begin
                    state_nxt = motor_bus_pkg::ST_LOCKED;
                end
            end
            motor_bus_pkg::ST_LOCKED: begin
                // bus ignored until high then low
                if (cs_s || low_expired) begin
                    state_nxt = motor_bus_pkg::ST_STANDBY;
                end
            end
            motor_bus_pkg::ST_STANDBY: begin
                if (fall && !ctrl_force_r) begin
                    state_nxt = motor_bus_pkg::ST_ACTIVE;
                end
            end
            motor_bus_pkg::ST_ACTIVE: begin
                if (ctrl_force_r || low_expired || (rise && zero_inputs)) begin
                    state_nxt = motor_bus_pkg::ST_STANDBY;
                end
            end
        endcase
    end

    // command register follows the bus while selected for writing
    always_comb begin
        cmd_nxt = cmd_r;
        if (state_nxt != motor_bus_pkg::ST_ACTIVE) begin
            cmd_nxt = '{default: motor_bus_pkg::DRV_OFF};
        end else if (wr_cycle) begin
            if (!mode_s && data_s == `DATA_CLEAR_CODE) begin
                cmd_nxt = '{default: motor_bus_pkg::DRV_OFF};
            end else begin
                cmd_nxt = decode_cmd(mode_s, data_s);
            end
        end
    end

    // stored command held after the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= motor_bus_pkg::ST_POWERUP;
            cmd_r <= '{default: motor_bus_pkg::DRV_OFF};
            wrote_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            wrote_r <= rise ? 1'b0 : (wrote_r | wr_cycle);
        end
    end

    // a stored write command rearms tripped outputs
    assign rearm = active & rise & wrote_r;
    assign armed[0] = active & (cmd_r.bridge_1 != motor_bus_pkg::DRV_OFF);
    assign armed[1] = active & (cmd_r.bridge_2 != motor_bus_pkg::DRV_OFF);
    assign armed[2] = active & (cmd_r.bridge_3 != motor_bus_pkg::DRV_OFF);
    assign armed[3] = active & (cmd_r.bridge_4 != motor_bus_pkg::DRV_OFF);
    assign armed[4] = active & (cmd_r.high_side != motor_bus_pkg::DRV_OFF);

    for (genvar i = 0; i < 5; i++) begin : g_ovc
        ovc_timer #(
            .TICKS(OVC_TICKS)
        ) u_ovc (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick_r),
            .armed(armed[i]),
            .vds_high(vds_above_40[i]),
            .rearm(rearm),
            .trip(trip[i]),
            .tripped(tripped[i])
        );
    end

    always_comb begin
        drv_nxt = cmd_r;
        if (tripped[0] || trip[0]) drv_nxt.bridge_1 = motor_bus_pkg::DRV_OFF;
        if (tripped[1] || trip[1]) drv_nxt.bridge_2 = motor_bus_pkg::DRV_OFF;
        if (tripped[2] || trip[2]) drv_nxt.bridge_3 = motor_bus_pkg::DRV_OFF;
        if (tripped[3] || trip[3]) drv_nxt.bridge_4 = motor_bus_pkg::DRV_OFF;
        if (tripped[4] || trip[4]) drv_nxt.high_side = motor_bus_pkg::DRV_OFF;
    end

    // hysteresis keeps the last crossed threshold
    assign lvl_nxt = level_above_60 | (lvl_r & ~level_below_40);

    // overvoltage outranks overcurrent, bridge before high side
    assign fault_code = overvoltage_in ? 2'h3 : (br_ovc_r ? 2'h1 : (hs_ovc_r ? 2'h2 : 2'h0));
    // with mode low, bit n carries bridge output n+1
    assign diag = mode_s ? {lvl_r[4], overtemp_in, fault_code} : lvl_r[3:0];

    // flags latch until a write command or leaving active; a new trip wins
    // diagnostics on the bus only while reading
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_r <= '{default: motor_bus_pkg::DRV_OFF};
            lvl_r <= 5'h00;
            br_ovc_r <= 1'b0;
            hs_ovc_r <= 1'b0;
            data_out_r <= 4'h0;
            data_oe_r <= 1'b0;
            standby_r <= 1'b0;
        end else begin
            drv_r <= drv_nxt;
            lvl_r <= lvl_nxt;
            br_ovc_r <= (|trip[3:0]) | (br_ovc_r & ~rearm & active);
            hs_ovc_r <= trip[4] | (hs_ovc_r & ~rearm & active);
            data_out_r <= rd_cycle ? diag : 4'h0;
            data_oe_r <= rd_cycle;
            standby_r <= (state_nxt == motor_bus_pkg::ST_STANDBY);
        end
    end

    // apb decode; one wait state so read data comes from a register
    assign access = psel & penable;
    assign apb_wr = access & pready_r & pwrite;
    assign sel_ctrl = (paddr == `CTRL_OFFSET);
    assign sel_status = (paddr == `STATUS_OFFSET);
    assign sel_cmd = (paddr == `CMD_OFFSET);
    assign rd_mux = sel_ctrl ? {31'h0, ctrl_force_r} :
                    sel_status ? {23'h0, lvl_r, hs_ovc_r, br_ovc_r, state_r} :
                    sel_cmd ? {17'h0, cmd_r} : 32'h0;

    // apb slave registers; unmapped offsets answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_force_r <= `CTRL_RESET;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= access & ~pready_r;
            pslverr_r <= access & ~pready_r & ~(sel_ctrl | sel_status | sel_cmd);
            prdata_r <= (access && !pready_r && !pwrite) ? rd_mux : 32'h0;
            if (apb_wr && sel_ctrl) begin
                ctrl_force_r <= pwdata[`CTRL_FORCE_STANDBY];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign data_out = data_out_r;
    assign data_oe = data_oe_r;
    assign bridge_output_1 = drv_r.bridge_1;
    assign bridge_output_2 = drv_r.bridge_2;
    assign bridge_output_3 = drv_r.bridge_3;
    assign bridge_output_4 = drv_r.bridge_4;
    assign high_side_output = drv_r.high_side;
    assign standby = standby_r;

    // checks on the block's outputs and internal state
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence read_status_s;
        active && !cs_s && rw_s && mode_s;
    endsequence

    sequence quiet_rise_s;
        active && rise && zero_inputs && !ctrl_force_r && !low_expired;
    endsequence

    AST_BUS_ONLY_READ: assert property (data_oe |-> $past(rd_cycle))
        else $error("data bus driven outside read mode");
    AST_LEVELS: assert property ((rd_cycle && !mode_s) |=> data_out == $past(lvl_r[3:0]))
        else $error("level readout wrong");
    AST_OVV_CODE: assert property ((read_status_s and overvoltage_in) |=> data_out[1:0] == 2'h3)
        else $error("overvoltage code wrong");
    AST_HOLD_DESELECTED: assert property ((active && cs_s && $past(cs_s) && !ctrl_force_r) |=> $stable(cmd_r))
        else $error("command changed while deselected");
    AST_LONG_LOW: assert property ((active && low_expired) |=> standby ##1 !active)
        else $error("long select low did not clear");
    AST_QUIET_RISE: assert property (quiet_rise_s |=> standby && cmd_r == '0)
        else $error("quiet rising edge did not enter standby");
    AST_POWERUP_HIGH: assert property ((state_r == motor_bus_pkg::ST_POWERUP && start_done && cs_s)
        |=> state_r == motor_bus_pkg::ST_STANDBY)
        else $error("powerup with select high not standby");
    AST_LOCKED_OFF: assert property ((state_r == motor_bus_pkg::ST_LOCKED) [*2] |-> drv_r == '0)
        else $error("outputs driven while bus locked");
    // compared on the outputs themselves: cmd_r runs one cycle ahead of them
    AST_HS_EXCLUSIVE: assert property ((high_side_output == motor_bus_pkg::DRV_SRC)
        |-> {bridge_output_4, bridge_output_3, bridge_output_2, bridge_output_1} == 12'h0)
        else $error("high side on with bridges active");
    AST_TRIP_OFF: assert property (trip[0] |=> bridge_output_1 == motor_bus_pkg::DRV_OFF && br_ovc_r)
        else $error("trip did not switch off and flag");
    AST_FLAG_CLEAR: assert property ((br_ovc_r && rearm && trip[3:0] == 4'h0) |=> !br_ovc_r)
        else $error("write command did not clear flag");
    AST_CLEAR_CODE: assert property ((wr_cycle && !mode_s && data_s == 4'hf) |=> cmd_r == '0)
        else $error("clear code left outputs on");

endmodule : motor_driver_bus_control

`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic pclk,
    input wire logic [3:0] bus_level,
    output logic chip_select_low,
    output logic read_not_write,
    output logic mode,
    output logic [3:0] host_data
);
    // idle bus: deselected, write direction
    initial begin
        chip_select_low = 1'b1;
        read_not_write = 1'b0;
        mode = 1'b0;
        host_data = 4'h0;
    end

    // park select low; the next pulse raises it
    task automatic hold_low();
        @(posedge pclk);
        chip_select_low <= 1'b0;
    endtask : hold_low

    // one select pulse of low+1 cycles (low 0 keeps select up); rd is the bus on its last low cycle
    task automatic pulse(input logic rw, input logic md, input logic [3:0] d, input int low, output logic [3:0] rd);
        @(posedge pclk);
        read_not_write <= rw;
        mode <= md;
        host_data <= d;
        repeat (200) @(posedge pclk);
        // short low pulse latches one word
        chip_select_low <= (low == 0);
        repeat (low) @(posedge pclk);
        @(negedge pclk);
        rd = bus_level;
        @(posedge pclk);
        chip_select_low <= 1'b1;
        // word held past the rising edge
        repeat (200) @(posedge pclk);
        host_data <= ~host_data; // a released bus shows no stale value
    endtask : pulse
endmodule : host_model

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam motor_bus_pkg::drive_t OF = motor_bus_pkg::DRV_OFF;
    localparam motor_bus_pkg::drive_t SR = motor_bus_pkg::DRV_SRC;
    localparam motor_bus_pkg::drive_t SK = motor_bus_pkg::DRV_SNK;
    localparam motor_bus_pkg::drive_t P1 = motor_bus_pkg::DRV_SRC_140;
    localparam motor_bus_pkg::drive_t N1 = motor_bus_pkg::DRV_SNK_140;
    localparam motor_bus_pkg::drive_t P0 = motor_bus_pkg::DRV_SRC_10;
    localparam motor_bus_pkg::drive_t N0 = motor_bus_pkg::DRV_SNK_10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, data_oe, ot, ov, standby, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic csl, rnw, md;
    logic [3:0] hd, dq, dout, rd;
    logic [4:0] lv, vds;
    motor_bus_pkg::drive_t b1, b2, b3, b4, hs;
    motor_bus_pkg::drive_set_t dx [12];
    logic [4:0] cmd [12] = '{5'h04, 5'h03, 5'h05, 5'h02, 5'h06, 5'h01, 5'h07, 5'h08, 5'h1a, 5'h11, 5'h16, 5'h0f};
    logic [15:0] exp_q [$];
    int error_cnt = 0;
    int check_count = 0;
    event res_ev;

    // resolved data lines: device wins while it drives
    assign dq = data_oe ? dout : hd;

    host_model u_host (.pclk(pclk), .bus_level(dq), .chip_select_low(csl), .read_not_write(rnw), .mode(md),
        .host_data(hd));

    // short tick and count parameters keep the run brief
    motor_driver_bus_control #(.OSC_DIV(4), .CLEAR_TICKS(3), .OVC_TICKS(2)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select_low(csl),
        .read_not_write(rnw), .mode(md), .data_in(dq), .data_out(dout), .data_oe(data_oe),
        .level_above_60(lv), .level_below_40(~lv), .vds_above_40(vds), .overtemp_in(ot), .overvoltage_in(ov),
        .bridge_output_1(b1), .bridge_output_2(b2), .bridge_output_3(b3), .bridge_output_4(b4),
        .high_side_output(hs), .standby(standby));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    function automatic motor_bus_pkg::drive_set_t ds(input motor_bus_pkg::drive_t a, b, c, d, h);
        return {h, d, c, b, a};
    endfunction : ds

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk

    // apb master: held until pready is seen, released on that same rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // answer taken at the rising edge that sees pready high; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // note the expected outputs once they have had time to settle
    task automatic expect_drv(input logic sb, input motor_bus_pkg::drive_set_t s);
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        exp_q.push_back({sb, s});
        ->res_ev;
        // hand back on a rising edge so the next stimulus lands there
        @(posedge pclk);
    endtask : expect_drv

    // monitor: oldest note against the drive outputs and standby
    initial forever begin
        @(res_ev);
        chk({standby, hs, b4, b3, b2, b1}, exp_q.pop_front());
    end

    // watchdog, several times the expected run length
    initial begin
        #(60000 * 5);
        error_cnt++;
        final_report();
    end

    initial begin
        void'($urandom(1));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lv = 5'h00;
        vds = 5'h00;
        ot = 1'b0;
        ov = 1'b0;
        dx = '{ds(SR, OF, OF, SK, OF), ds(SK, OF, OF, SR, OF), ds(OF, SR, OF, SK, OF), ds(OF, SK, OF, SR, OF),
            ds(OF, OF, SR, SK, OF), ds(OF, OF, SK, SR, OF), ds(SK, SK, SK, SK, OF), ds(OF, OF, OF, OF, SR),
            ds(OF, OF, OF, P1, OF), ds(OF, OF, OF, N1, OF), ds(N0, N0, N0, P1, P0), '0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(r[1:0], 2'h2);
        // every decoded write code; braking precedes the stop
        for (int i = 0; i < 12; i++) begin
            u_host.pulse(1'b0, cmd[i][4], cmd[i][3:0], 4, rd);
            expect_drv(1'b0, dx[i]);
        end
        u_host.pulse(1'b0, 1'b0, 4'h4, 0, rd);
        expect_drv(1'b0, '0);
        u_host.pulse(1'b0, 1'b0, 4'h4, 4, rd);
        vds <= 5'h01;
        repeat (40) @(posedge pclk);
        expect_drv(1'b0, ds(OF, OF, OF, SK, OF));
        u_host.pulse(1'b1, 1'b1, 4'h0, 4, rd);
        chk(rd[1:0], 2'h1);
        vds <= 5'h00;
        u_host.pulse(1'b0, 1'b0, 4'h4, 4, rd);
        expect_drv(1'b0, ds(SR, OF, OF, SK, OF));
        for (int i = 0; i < 4; i++) begin
            lv <= 5'($urandom);
            ot <= 1'($urandom);
            ov <= 1'(i);
            u_host.pulse(1'b1, 1'(i >> 1), 4'($urandom), 4, rd);
            chk(rd, (i > 1) ? {lv[4], ot, ov, ov} : lv[3:0]);
        end
        expect_drv(1'b0, ds(SR, OF, OF, SK, OF));
        u_host.hold_low();
        u_host.pulse(1'b0, 1'b0, 4'h5, 0, rd);
        expect_drv(1'b1, '0);
        u_host.pulse(1'b0, 1'b0, 4'h4, 4, rd);
        expect_drv(1'b0, ds(SR, OF, OF, SK, OF));
        apb(1'b1, 8'h00, 32'h1);
        expect_drv(1'b1, '0);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        u_host.pulse(1'b0, 1'b0, 4'h0, 4, rd);
        expect_drv(1'b1, '0);
        u_host.hold_low();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk(r[1:0], 2'h1);
        // select still held low: the long low alone must reach standby
        repeat (20) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk(r[1:0], 2'h2);
        u_host.pulse(1'b0, 1'b0, 4'h4, 0, rd);
        expect_drv(1'b1, '0);
        final_report();
    end
endmodule : tb

`default_nettype wire
